// ===== verilog/arp_pkg.sv
// Purpose: shared constants and types for the converter result output port
// Assumes: one 100 MHz system clock, all host pins asynchronous to it
// Notes: pin index constants address the synchroniser vector
package arp_pkg;

	// result geometry
	localparam int RESULT_W = 10;
	localparam int BYTE_W = 8;
	localparam int LSB_PART_W = RESULT_W - BYTE_W;
	localparam int FIFO_DEPTH = 16;

	// serial bit counter: 0 = done marker, 1..10 = bits shown, 11 = readout over
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
	localparam logic [CNT_W-1:0] CNT_LAST_BIT = 4'ha;
	localparam logic [CNT_W-1:0] CNT_OVER = 4'hb;

	// host pin positions in the synchroniser vector
	localparam int PIN_N = 5;
	localparam int PIN_CS_N = 0;
	localparam int PIN_SHIFT_CLK = 1;
	localparam int PIN_READ_CONV = 2;
	localparam int PIN_FORMAT = 3;
	localparam int PIN_BYTE_SEL = 4;
	// pins idle: deselected, shift clock low, read mode, 10-bit format
	localparam logic [PIN_N-1:0] PIN_RESET = 5'h0d;

	// host shift clock ceiling, kept by the host
	localparam int SHIFT_CLK_MAX_HZ = 10_000_000;

	// sequencer states
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_DONE = 3'b100
	} arp_state_t;

endpackage : arp_pkg

// ===== verilog/arp_fifo.sv
// Purpose: result buffer between the conversion core and the output port
// Assumes: single clock, clock enable freezes all state
// Notes: ready and valid both come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module arp_fifo
	import arp_pkg::*;
#(
	parameter int WIDTH = RESULT_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);

	localparam int AW = $clog2(DEPTH);

	// pointers must wrap naturally
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("arp_fifo: DEPTH must be a power of two, at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic not_full;
		logic not_empty;
	} arp_fifo_st_t;

	arp_fifo_st_t r_r;
	arp_fifo_st_t r_nxt;
	logic push;
	logic pop;

	assign push = i_in_valid & r_r.not_full;
	assign pop = i_out_ready & r_r.not_empty;

	// next state: write, read, recompute flags
	always_comb
	begin
		r_nxt = r_r;
		if (push)
		begin
			r_nxt.mem[r_r.wp] = i_in_data;
			r_nxt.wp = r_r.wp + 1'b1;
		end
		if (pop)
		begin
			r_nxt.rp = r_r.rp + 1'b1;
		end
		r_nxt.cnt = r_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
		r_nxt.not_full = (r_nxt.cnt != (AW+1)'(DEPTH));
		r_nxt.not_empty = (r_nxt.cnt != '0);
	end

	// state register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, not_full: 1'b1, not_empty: 1'b0};
		end
		else if (i_ce)
		begin
			r_r <= r_nxt;
		end
	end

	assign o_in_ready = r_r.not_full;
	assign o_out_valid = r_r.not_empty;
	assign o_out_data = r_r.mem[r_r.rp];

endmodule : arp_fifo

`default_nettype wire

// ===== verilog/arp_result_port.sv
// Purpose: serial and parallel result output port of a 10-bit converter
// Assumes: host pins are asynchronous; results arrive as a valid/ready stream
// Notes: shift clock is sampled by i_clk, falling edges found after filtering
// Operation
// - serial output floats whenever chip select is high.
// - selected serial output is low during conversion, high when it completes.
// - after completion each of the first ten shift clock falling edges shows next bit, MSB first.
// - ten tri-state parallel lines, line 9 MSB, line 0 LSB.
// - active-low done flag asserts once a result is available.
// - format select low gives two 8-bit words, high one 10-bit word.
// - in byte mode, byte select low gives 8 MSBs, high the 2 LSBs, rest zero.
`timescale 1ns/1ps
`default_nettype none

module arp_result_port
	import arp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_chip_select_low,
	input wire logic i_shift_clk,
	input wire logic i_read_convert,
	input wire logic i_word_format_select,
	input wire logic i_byte_select,
	input wire logic i_core_valid,
	input wire logic [RESULT_W-1:0] i_core_data,
	output logic o_core_ready,
	output logic o_conv_start,
	output logic o_serial_out,
	output logic o_serial_oe_n,
	output logic [RESULT_W-1:0] o_parallel_result,
	output logic o_parallel_oe_n,
	output logic o_conversion_done_low
);

	typedef struct packed {
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		logic [PIN_N-1:0] pin_f;
		arp_state_t st;
		logic [RESULT_W-1:0] result;
		logic [CNT_W-1:0] bitcnt;
		logic start;
		logic sout;
		logic sout_oe_n;
		logic [RESULT_W-1:0] par;
		logic par_oe_n;
		logic done_n;
	} arp_port_st_t;

	arp_port_st_t r_r;
	arp_port_st_t r_nxt;
	logic [PIN_N-1:0] pins;
	logic fifo_valid;
	logic [RESULT_W-1:0] fifo_data;
	logic fifo_pop;
	logic fall;
	logic sel;
	arp_port_st_t r_nxt_full;

	assign pins = {i_byte_select, i_word_format_select, i_read_convert, i_shift_clk, i_chip_select_low};
	assign fifo_pop = (r_r.st == ST_CONV);

	// result buffer from the conversion core
	arp_fifo #(
		.WIDTH(RESULT_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_ce(i_ce),
		.i_in_valid(i_core_valid),
		.i_in_data(i_core_data),
		.o_in_ready(o_core_ready),
		.o_out_valid(fifo_valid),
		.o_out_data(fifo_data),
		.i_out_ready(fifo_pop)
	);

	// edge and select decode from filtered pins
	always_comb
	begin
		logic [PIN_N-1:0] agree;
		agree = ~(r_r.s2 ^ r_r.s3);
		r_nxt = r_r;
		r_nxt.s1 = pins;
		r_nxt.s2 = r_r.s1;
		r_nxt.s3 = r_r.s2;
		// change counts once stages two and three agree
		r_nxt.pin_f = (agree & r_r.s3) | (~agree & r_r.pin_f);
		fall = r_r.pin_f[PIN_SHIFT_CLK] & ~r_nxt.pin_f[PIN_SHIFT_CLK];
		sel = ~r_nxt.pin_f[PIN_CS_N];
	end

	// sequencer, serial and parallel output drive
	always_comb
	begin
		arp_port_st_t n;
		logic [CNT_W-1:0] idx;
		n = r_nxt;
		n.start = 1'b0;
		idx = '0;
		case (r_r.st)
			ST_IDLE, ST_DONE:
			begin
				// convert request: selected with read/convert low
				if (sel && !n.pin_f[PIN_READ_CONV])
				begin
					n.st = ST_CONV;
					n.start = 1'b1;
					n.done_n = 1'b1;
					n.bitcnt = CNT_RESET;
				end
				else if (r_r.st == ST_DONE && fall && r_r.bitcnt != CNT_OVER)
				begin
					n.bitcnt = r_r.bitcnt + 1'b1;
				end
			end
			ST_CONV:
			begin
				if (fifo_valid)
				begin
					n.st = ST_DONE;
					n.result = fifo_data;
					n.done_n = 1'b0;
					n.bitcnt = CNT_RESET;
				end
			end
			default:
			begin
				n.st = ST_IDLE;
			end
		endcase
		// serial line: low in conversion, high at done, then bits MSB first
		n.sout = 1'b0;
		if (n.st == ST_DONE)
		begin
			if (n.bitcnt == CNT_RESET)
			begin
				n.sout = 1'b1;
			end
			else if (n.bitcnt <= CNT_LAST_BIT)
			begin
				idx = CNT_W'(RESULT_W) - n.bitcnt;
				n.sout = n.result[idx];
			end
		end
		n.sout_oe_n = n.pin_f[PIN_CS_N];
		// parallel lines enabled for a selected read
		n.par_oe_n = ~(sel & n.pin_f[PIN_READ_CONV]);
		if (n.pin_f[PIN_FORMAT])
		begin
			n.par = n.result;
		end
		else if (!n.pin_f[PIN_BYTE_SEL])
		begin
			n.par = {n.result[RESULT_W-1 -: BYTE_W], {LSB_PART_W{1'b0}}};
		end
		else
		begin
			n.par = {n.result[LSB_PART_W-1:0], {BYTE_W{1'b0}}};
		end
		r_nxt_full = n;
	end

	// state register, frozen while clock enable is low
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			r_r <= '{s1: PIN_RESET, s2: PIN_RESET, s3: PIN_RESET, pin_f: PIN_RESET, st: ST_IDLE,
				result: '0, bitcnt: CNT_RESET, start: 1'b0, sout: 1'b0, sout_oe_n: 1'b1,
				par: '0, par_oe_n: 1'b1, done_n: 1'b1};
		end
		else if (i_ce)
		begin
			r_r <= r_nxt_full;
		end
	end

	assign o_conv_start = r_r.start;
	assign o_serial_out = r_r.sout;
	assign o_serial_oe_n = r_r.sout_oe_n;
	assign o_parallel_result = r_r.par;
	assign o_parallel_oe_n = r_r.par_oe_n;
	assign o_conversion_done_low = r_r.done_n;

	// checks on the port behaviour
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_done_marker;
		i_ce && r_r.st == ST_DONE && r_r.bitcnt == CNT_RESET && fall && !(sel && !r_nxt.pin_f[PIN_READ_CONV]);
	endsequence

	sequence s_next_bit;
		i_ce && r_r.st == ST_DONE && fall && r_r.bitcnt >= 4'h1 && r_r.bitcnt < CNT_LAST_BIT
			&& !(sel && !r_nxt.pin_f[PIN_READ_CONV]);
	endsequence

	a_serial_float: assert property (r_r.pin_f[PIN_CS_N] |-> o_serial_oe_n)
		else $error("serial output driven while deselected");
	a_serial_low_conv: assert property (r_r.st == ST_CONV |-> !o_serial_out && o_conversion_done_low)
		else $error("serial output not low during conversion");
	a_result_capture: assert property (i_ce && r_r.st == ST_CONV && fifo_valid
		|=> !o_conversion_done_low && o_serial_out && r_r.result == $past(fifo_data))
		else $error("completion not flagged after result arrival");
	a_msb_first: assert property (s_done_marker |=> o_serial_out == r_r.result[RESULT_W-1])
		else $error("first shifted bit is not the MSB");
	a_bit_order: assert property (s_next_bit
		|=> o_serial_out == r_r.result[RESULT_W-1-int'($past(r_r.bitcnt))])
		else $error("shifted bit out of order");
	a_readout_end: assert property (r_r.st == ST_DONE && r_r.bitcnt == CNT_OVER |-> !o_serial_out)
		else $error("serial output active after ten bits");
	a_readout_hold: assert property (i_ce && r_r.st == ST_DONE && r_r.bitcnt == CNT_OVER && fall
		&& !(sel && !r_nxt.pin_f[PIN_READ_CONV]) |=> r_r.bitcnt == CNT_OVER && !o_serial_out)
		else $error("extra shift edge moved the finished readout");
	a_word_format: assert property (!o_parallel_oe_n && r_r.pin_f[PIN_FORMAT]
		|-> o_parallel_result == r_r.result)
		else $error("10-bit parallel word wrong");
	a_byte_format: assert property (!o_parallel_oe_n && !r_r.pin_f[PIN_FORMAT]
		|-> o_parallel_result[LSB_PART_W-1:0] == '0 && (r_r.pin_f[PIN_BYTE_SEL]
		? o_parallel_result == {r_r.result[LSB_PART_W-1:0], {BYTE_W{1'b0}}}
		: o_parallel_result[RESULT_W-1:LSB_PART_W] == r_r.result[RESULT_W-1:LSB_PART_W]))
		else $error("byte-format parallel word wrong");

endmodule : arp_result_port

`default_nettype wire

// ===== bench/arp_host_model.sv
// Purpose: host model driving chip select, shift clock and mode pins
// Assumes: pins move 1 ns after a rising edge of the system clock
// Notes: shift clock stands low outside readouts
`timescale 1ns/1ps
`default_nettype none

module arp_host_model
	import arp_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_serial_out,
	input wire logic i_serial_oe_n,
	output logic o_chip_select_low,
	output logic o_shift_clk,
	output logic o_read_convert,
	output logic o_word_format_select,
	output logic o_byte_select
);
	// serial line as seen by the host, floating when released
	wire logic serial_line = i_serial_oe_n ? 1'bz : i_serial_out;

	// idle pins: deselected, shift clock low, read mode
	initial
	begin
		o_chip_select_low = 1'b1;
		o_shift_clk = 1'b0;
		o_read_convert = 1'b1;
		o_word_format_select = 1'b1;
		o_byte_select = 1'b0;
	end

	// wait n edges, then step off the edge
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	// set select and format pins together
	task automatic pins(input logic cs_n, input logic fmt, input logic bsel);
		step(1);
		o_chip_select_low = cs_n;
		o_word_format_select = fmt;
		o_byte_select = bsel;
	endtask : pins

	// convert request: read/convert low for len cycles, shift clock left low
	task automatic convert(input int len);
		step(1);
		o_read_convert = 1'b0;
		step(len);
		o_read_convert = 1'b1;
	endtask : convert

	// one 160 ns shift period, bit sampled at the end of the low half
	task automatic shift(output logic b);
		o_shift_clk = 1'b1;
		step(8);
		o_shift_clk = 1'b0;
		step(8);
		b = serial_line;
	endtask : shift
endmodule : arp_host_model
`default_nettype wire

// ===== bench/testbench.sv
// Purpose: self-checking bench for the result output port
// Assumes: host model owns the pins, bench owns the core stream
// Notes: pin changes need 4 cycles to reach the outputs
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import arp_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic core_valid = 1'b0;
	logic [RESULT_W-1:0] core_data = 10'h000;
	wire logic cs_n, sclk, rc, fmt, bsel;
	wire logic o_core_ready, o_conv_start, o_serial_out, o_serial_oe_n;
	wire logic o_parallel_oe_n, o_conversion_done_low;
	wire logic [RESULT_W-1:0] o_parallel_result;
	int num_errors = 0;
	int n_tests = 0;

	// 100 MHz system clock
	always #5 clk = ~clk;

	arp_result_port i_arp_result_port (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
		.i_chip_select_low(cs_n), .i_shift_clk(sclk), .i_read_convert(rc),
		.i_word_format_select(fmt), .i_byte_select(bsel), .i_core_valid(core_valid),
		.i_core_data(core_data), .o_core_ready(o_core_ready), .o_conv_start(o_conv_start),
		.o_serial_out(o_serial_out), .o_serial_oe_n(o_serial_oe_n),
		.o_parallel_result(o_parallel_result), .o_parallel_oe_n(o_parallel_oe_n),
		.o_conversion_done_low(o_conversion_done_low));

	arp_host_model host (.i_clk(clk), .i_serial_out(o_serial_out), .i_serial_oe_n(o_serial_oe_n),
		.o_chip_select_low(cs_n), .o_shift_clk(sclk), .o_read_convert(rc),
		.o_word_format_select(fmt), .o_byte_select(bsel));

	// counts and verdict, then end of run
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	// compare seen against expected
	task automatic check(input logic [RESULT_W-1:0] seen, input logic [RESULT_W-1:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// hand one word to the fifo, held until taken
	task automatic push(input logic [RESULT_W-1:0] w);
		int k;
		@(posedge clk);
		#1;
		core_valid = 1'b1;
		core_data = w;
		for (k = 0; k < 40 && o_core_ready !== 1'b1; k++)
			host.step(1);
		if (k == 40)
		begin
			num_errors++;
			stop_test();
		end
		host.step(1);
		core_valid = 1'b0;
	endtask : push

	// bounded wait for the done flag
	task automatic wait_done;
		int k;
		for (k = 0; k < 40 && o_conversion_done_low !== 1'b0; k++)
			host.step(1);
		check(RESULT_W'(o_conversion_done_low), 10'h000);
		if (k == 40)
			stop_test();
	endtask : wait_done

	// outputs while reset is held
	task automatic t_reset;
		check(RESULT_W'(o_serial_oe_n), 10'h001);
		check(RESULT_W'(o_conversion_done_low), 10'h001);
		check(RESULT_W'(o_core_ready), 10'h001);
	endtask : t_reset

	// conversion, serial readout, all parallel formats, deselect
	task automatic t_serial(input logic [RESULT_W-1:0] w);
		logic b;
		host.pins(1'b0, 1'b1, 1'b0);
		host.convert(6);
		host.step(8);
		check(RESULT_W'(o_serial_oe_n), 10'h000);
		check(RESULT_W'(o_serial_out), 10'h000);
		check(RESULT_W'(o_conversion_done_low), 10'h001);
		push(w);
		wait_done();
		host.step(1);
		check(RESULT_W'(o_serial_out), 10'h001);
		for (int i = 0; i < RESULT_W; i++)
		begin
			host.shift(b);
			check(RESULT_W'(b), RESULT_W'(w[RESULT_W-1-i]));
		end
		host.shift(b);
		check(RESULT_W'(b), 10'h000);
		host.step(8);
		check(o_parallel_result, w);
		host.pins(1'b0, 1'b0, 1'b0);
		host.step(8);
		check(o_parallel_result, {w[9:2], 2'h0});
		host.pins(1'b0, 1'b0, 1'b1);
		host.step(8);
		check(o_parallel_result, {w[1:0], 8'h00});
		check(RESULT_W'(o_parallel_oe_n), 10'h000);
		host.pins(1'b1, 1'b1, 1'b0);
		host.step(8);
		check(RESULT_W'(o_serial_oe_n), 10'h001);
		check(RESULT_W'(o_parallel_oe_n), 10'h001);
	endtask : t_serial

	// fill fifo until refused, then held convert drains it one word each
	task automatic t_fill;
		int starts;
		starts = 0;
		for (int i = 0; i < FIFO_DEPTH; i++)
			push(RESULT_W'(10'h100 + i));
		check(RESULT_W'(o_core_ready), 10'h000);
		host.pins(1'b0, 1'b1, 1'b0);
		host.step(8);
		fork
			host.convert(80);
			repeat (90)
			begin
				host.step(1);
				if (o_conv_start === 1'b1)
					starts++;
			end
		join
		check(RESULT_W'(starts), RESULT_W'(FIFO_DEPTH + 1));
		check(RESULT_W'(o_core_ready), 10'h001);
		check(RESULT_W'(o_conversion_done_low), 10'h001);
		push(10'h3c7);
		wait_done();
		host.step(2);
		check(o_parallel_result, 10'h3c7);
	endtask : t_fill

	// clock enable low freezes pins and outputs, release lets them move
	task automatic t_freeze;
		host.pins(1'b0, 1'b1, 1'b0);
		host.step(8);
		check(RESULT_W'(o_serial_oe_n), 10'h000);
		ce = 1'b0;
		host.pins(1'b1, 1'b1, 1'b0);
		host.step(8);
		check(RESULT_W'(o_serial_oe_n), 10'h000);
		check(RESULT_W'(o_parallel_oe_n), 10'h000);
		ce = 1'b1;
		host.step(8);
		check(RESULT_W'(o_serial_oe_n), 10'h001);
		check(RESULT_W'(o_parallel_oe_n), 10'h001);
	endtask : t_freeze

	// main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		t_reset();
		#1;
		arst_n = 1'b1;
		host.step(4);
		t_serial(10'h2d5);
		t_serial(10'h12a);
		t_fill();
		t_freeze();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
